// File: verilog/csm_pkg.sv
// constants and types shared by the main clock stop monitor
// assumes a single 40 MHz system clock and an AHB-Lite register slave
package csm_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CSM_MODE_OFS = 8'h00;
    localparam logic [7:0] CSM_KEY_OFS = 8'h04;
    localparam logic [7:0] CSM_RSRC_OFS = 8'h08;
    localparam logic [7:0] CSM_STAT_OFS = 8'h0c;
    // field positions, the mode value after reset and the key value
    localparam int CSM_ENABLE_BIT = 0;
    localparam int CSM_FLAG_BIT = 0;
    localparam int CSM_ACTIVE_BIT = 0;
    localparam int CSM_REQ_BIT = 1;
    localparam logic [7:0] CSM_MODE_RST = 8'h00;
    localparam logic [7:0] CSM_KEY_VAL = 8'ha5;
    // sampling defaults: hclk cycles per sample, silent samples to fail
    localparam int CSM_SAMPLE_DIV = 4;
    localparam int CSM_STOP_TICKS = 8;

    // clock-system status inputs that can pause monitoring
    typedef struct packed {
        logic stop_mode;
        logic osc_settling;
        logic main_osc_halt;
        logic cpu_clock_status;
        logic internal_osc_stop;
        logic internal_osc_cpu_flag;
    } csm_ctl_t;

    // protected write sequencer
    typedef enum logic {CSM_LOCKED, CSM_UNLOCKED} csm_prot_t;
endpackage : csm_pkg

// File: verilog/csm_stop_det.sv
// main clock transition detector for the clock stop monitor
// assumes main_clk is already a level synchronous to hclk
`timescale 1ns/10ps
module csm_stop_det
    import csm_pkg::*;
#(
    parameter int SAMPLE_DIV = CSM_SAMPLE_DIV,
    parameter int STOP_TICKS = CSM_STOP_TICKS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic main_clk,
    input wire logic active,
    output logic stopped
);
    localparam int DW = $clog2(SAMPLE_DIV + 1);
    localparam int GW = $clog2(STOP_TICKS + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(SAMPLE_DIV - 1);
    localparam logic [GW-1:0] GAP_LAST = GW'(STOP_TICKS - 1);

    logic [DW-1:0] div_q;
    logic [GW-1:0] gap_q;
    logic prev_q;
    wire tick = (div_q == DIV_LAST);
    wire edge_seen = (main_clk != prev_q);
    // a stop is declared after STOP_TICKS silent sample ticks
    assign stopped = active && tick && !edge_seen && (gap_q == GAP_LAST); // see RQ14

    // sample divider and silent-tick counter; pausing clears the count so
    // a resumed monitor never trips on stale silence
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q <= '0;
            gap_q <= '0;
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= main_clk;
            div_q <= tick ? '0 : div_q + 1'b1;
            if (!active || edge_seen || stopped)
                gap_q <= '0;
            else if (tick)
                gap_q <= gap_q + 1'b1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_STOP_SILENT: assert property (@(posedge hclk) disable iff (!hresetn)
        stopped |-> !edge_seen && active && $stable(main_clk)) // see RQ14
        else $error("stop declared despite main clock edge");
endmodule : csm_stop_det

// File: verilog/csm_monitor.sv
// main clock stop monitor with protected mode register on AHB-Lite
// assumes all control inputs are synchronous to hclk; hresetn is the
// external reset, and the reset request drives system reset elsewhere
`timescale 1ns/10ps
// Overview of operation
// RQ1: the main clock is sampled and a stop while active requests reset.
// RQ2: once the enable bit is set, writes cannot clear it; only reset can.
// RQ3: a monitor-caused reset sets the clock-fail reset-source flag.
// RQ4: the mode register is 8 bits, enable at bit 0, others zero, resets 0.
// RQ5: writing 1 to the enable bit starts monitoring; 0 means disabled.
// RQ6: the mode register only takes a write right after the key sequence.
// RQ7: the mode register takes byte and single-bit (byte lane) accesses.
// RQ8: stop mode and the following settling count pause monitoring.
// RQ9: subclock running with main osc halted pauses until main reselected.
// RQ10: a stopped sampling oscillator suspends monitoring and any reset.
// RQ11: monitoring is suspended while the CPU runs on the internal osc.
// RQ12: external reset clears enable; software re-enables after settling.
// RQ13: in sub-idle the monitor runs if main osc runs, stops if halted.
// RQ14: a stop is declared after a fixed count of silent sample periods.
module csm_monitor
    import csm_pkg::*;
#(
    parameter int SAMPLE_DIV = CSM_SAMPLE_DIV,
    parameter int STOP_TICKS = CSM_STOP_TICKS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic main_clk,
    input wire csm_ctl_t ctl,
    output logic clock_fail_reset_req,
    output logic clock_fail_reset_flag,
    output logic monitor_active
);
    // ****************************************
    // bus address phase capture
    // ****************************************
    logic dp_valid_q;
    logic dp_write_q;
    logic [7:0] dp_addr_q;
    logic dp_lane0_q;
    wire ap_take = hsel && hready && htrans[1];

    // the slave never stalls, so each address phase is taken at once
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 8'h00;
            dp_lane0_q <= 1'b0;
        end
        else
        begin
            dp_valid_q <= ap_take;
            dp_write_q <= hwrite;
            dp_addr_q <= {haddr[7:2], 2'b00};
            dp_lane0_q <= (haddr[1:0] == 2'b00) && (hsize <= 3'h2);
        end
    end

    // data phase decode; byte lane 0 carries every writable bit
    wire dp_wr = dp_valid_q && dp_write_q;
    wire dp_rd = dp_valid_q && !dp_write_q;
    wire sel_mode = (dp_addr_q == CSM_MODE_OFS);
    wire sel_key = (dp_addr_q == CSM_KEY_OFS);
    wire sel_rsrc = (dp_addr_q == CSM_RSRC_OFS);
    wire sel_stat = (dp_addr_q == CSM_STAT_OFS);
    wire key_hit = dp_wr && sel_key && dp_lane0_q &&
        (hwdata[7:0] == CSM_KEY_VAL);
    wire mode_wr = dp_wr && sel_mode && dp_lane0_q; // see RQ7

    // ****************************************
    // protected write sequence
    // ****************************************
    csm_prot_t prot_q;
    csm_prot_t prot_d;
    // a key write opens exactly one following write, to any register, which relocks; reads leave it open
    always_comb
    begin
        case (prot_q)
            CSM_LOCKED: prot_d = key_hit ? CSM_UNLOCKED : CSM_LOCKED;
            CSM_UNLOCKED: prot_d = dp_wr ? CSM_LOCKED : CSM_UNLOCKED;
            default: prot_d = CSM_LOCKED;
        endcase
    end
    wire mode_wr_ok = mode_wr && (prot_q == CSM_UNLOCKED); // see RQ6

    // ****************************************
    // mode register and pause conditions
    // ****************************************
    logic enable_q;
    logic halt_pause_q;
    logic req_q;
    logic flag_q;
    logic stopped;
    // writes of 0 are dropped: the bit is set-only until reset
    wire enable_d = enable_q || (mode_wr_ok && hwdata[CSM_ENABLE_BIT]); // see RQ2
    // main osc halt pauses from the halt until main clock is reselected,
    // so sub-idle with the oscillator running keeps monitoring
    wire halt_pause_d = ctl.main_osc_halt ||
        (halt_pause_q && ctl.cpu_clock_status); // see RQ9
    wire paused = ctl.stop_mode || ctl.osc_settling // see RQ8
        || halt_pause_q || ctl.main_osc_halt // see RQ13
        || ctl.internal_osc_stop // see RQ10
        || ctl.internal_osc_cpu_flag; // see RQ11
    wire active = enable_q && !paused && !req_q; // see RQ5
    wire flag_clr = dp_wr && sel_rsrc && dp_lane0_q && hwdata[CSM_FLAG_BIT];

    // external reset clears enable and stops monitoring
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prot_q <= CSM_LOCKED;
            enable_q <= CSM_MODE_RST[CSM_ENABLE_BIT]; // see RQ4, RQ12
            halt_pause_q <= 1'b0;
            req_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            prot_q <= prot_d;
            enable_q <= enable_d;
            halt_pause_q <= halt_pause_d;
            req_q <= req_q || stopped; // see RQ1
            // a new failure wins over a same-cycle software clear
            flag_q <= stopped || (flag_q && !flag_clr); // see RQ3
        end
    end

    csm_stop_det #(
        .SAMPLE_DIV(SAMPLE_DIV),
        .STOP_TICKS(STOP_TICKS)
    ) u_det (
        .hclk(hclk),
        .hresetn(hresetn),
        .main_clk(main_clk),
        .active(active),
        .stopped(stopped)
    );

    // ****************************************
    // outputs and read mux
    // ****************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign clock_fail_reset_req = req_q;
    assign clock_fail_reset_flag = flag_q;
    assign monitor_active = active;
    // read mux over flops and the combinational active bit; unmapped addresses read zero
    wire [31:0] rd_mode = {31'h0, enable_q}; // see RQ4
    wire [31:0] rd_rsrc = {31'h0, flag_q};
    wire [31:0] rd_stat = {30'h0, req_q, active};
    assign hrdata = !dp_rd ? 32'h0 :
        sel_mode ? rd_mode :
        sel_rsrc ? rd_rsrc :
        sel_stat ? rd_stat : 32'h0;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_FAIL_REQ: assert property (stopped |=> clock_fail_reset_req [*3]) // see RQ1
        else $error("stop did not raise a held reset request");
    AST_EN_STICKY: assert property (enable_q |=> enable_q) // see RQ2
        else $error("enable bit cleared without reset");
    AST_FLAG_SET: assert property (stopped |=> flag_q) // see RQ3
        else $error("clock fail flag not set");
    AST_MODE_ZERO: assert property (dp_rd && sel_mode |-> hrdata[31:1] == 31'h0) // see RQ4
        else $error("mode register upper bits not zero");
    AST_EN_WRITE: assert property (mode_wr_ok && hwdata[0] |=> enable_q) // see RQ5
        else $error("protected write of 1 did not enable");
    AST_LOCKED: assert property (mode_wr && prot_q == CSM_LOCKED && !enable_q |=> !enable_q) // see RQ6
        else $error("unprotected write changed mode");
    AST_KEY_OPEN: assert property (prot_q == CSM_UNLOCKED && mode_wr && hwdata[0] |=> enable_q) // see RQ7
        else $error("key then lane0 write failed to enable");
    AST_STOP_PAUSE: assert property (ctl.stop_mode || ctl.osc_settling |-> !active && !stopped) // see RQ8
        else $error("monitor ran during stop or settling");
    AST_HALT_PAUSE: assert property (ctl.main_osc_halt ##1 ctl.cpu_clock_status |-> !active) // see RQ9
        else $error("monitor ran while main osc halted");
    AST_ROSC_STOP: assert property (ctl.internal_osc_stop |=> !$rose(req_q)) // see RQ10
        else $error("reset issued with sampling osc stopped");
    AST_ROSC_CPU: assert property (ctl.internal_osc_cpu_flag |-> !active) // see RQ11
        else $error("monitor ran on internal osc cpu clock");
endmodule : csm_monitor

// File: sim/csm_main_osc_model.sv
// behavioural main oscillator, seen as a level synchronous to hclk
// assumes the bench drives run; a halted oscillator holds its level
`timescale 1ns/10ps
module csm_main_osc_model
#(
    parameter int HALF_CYCLES = 3
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    output logic main_clk
);
    logic [7:0] cnt_q;
    logic main_clk_q;
    // odd half period so it never aliases with an even sample divider
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q <= 8'h00;
            main_clk_q <= 1'b0;
        end
        else if (run && cnt_q == 8'(HALF_CYCLES - 1))
        begin
            cnt_q <= 8'h00;
            main_clk_q <= !main_clk_q;
        end
        else if (run)
            cnt_q <= cnt_q + 8'h01;
    end
    assign main_clk = main_clk_q;
endmodule : csm_main_osc_model

// File: sim/test_csm_monitor.sv
// self-checking bench for the main clock stop monitor
// assumes one AHB-Lite slave whose hreadyout closes the hready loop
`timescale 1ns/10ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module test_csm_monitor
    import csm_pkg::*;
;
    localparam int SILENT = CSM_SAMPLE_DIV * CSM_STOP_TICKS;
    logic hclk, hresetn, hsel, hwrite, run, hreadyout, hresp;
    logic main_clk, req, flag, active;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    csm_ctl_t ctl;
    wire hready = hreadyout;
    int err_count, n_checks;
    int pb[4] = '{5, 4, 1, 0};
    csm_monitor csm_monitor_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .main_clk(main_clk), .ctl(ctl), .clock_fail_reset_req(req),
        .clock_fail_reset_flag(flag), .monitor_active(active));
    csm_main_osc_model csm_main_osc_model_inst (.hclk(hclk),
        .hresetn(hresetn), .run(run), .main_clk(main_clk));
    // ****************************************
    // bus and checking tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    // one single transfer; waits on hready, no fixed latency assumed
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [2:0] sz, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic rdc(input string n, input logic [7:0] a,
        input logic [31:0] e);
        xfer(1'b0, a, 3'b010, 32'h00000000);
        `CHK(n, e, rd);
    endtask : rdc
    // key write then mode write, back to back
    task automatic prot(input logic [2:0] sz, input logic [31:0] d);
        xfer(1'b1, CSM_KEY_OFS, 3'b000, {24'h000000, CSM_KEY_VAL});
        xfer(1'b1, CSM_MODE_OFS, sz, d);
    endtask : prot
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    // ****************************************
    // clock, watchdog and test sequence
    // ****************************************
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = !hclk;
    end
    // whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge hclk);
        err_count++;
        conclude();
    end
    initial
    begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        ctl = '0;
        run = 1'b1;
        err_count = 0;
        n_checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("mode reset", CSM_MODE_OFS, 0);
        `CHK("okay resp", 0, hresp);
        `CHK("no wait", 1, hreadyout);
        rdc("stat reset", CSM_STAT_OFS, 0);
        rdc("rsrc reset", CSM_RSRC_OFS, 0);
        rdc("unmapped", 8'h10, 0);
        xfer(1'b1, CSM_MODE_OFS, 3'b010, 32'h00000001);
        rdc("mode no key", CSM_MODE_OFS, 0);
        prot(3'b000, 32'h000000ff);
        rdc("mode byte set", CSM_MODE_OFS, 1);
        `CHK("active on", 1, active);
        prot(3'b010, 32'h00000000);
        rdc("mode clear", CSM_MODE_OFS, 1);
        $display("test registers done");
        // stop mode, settling and both internal osc statuses each hold off a stop with the clock halted
        foreach (pb[i])
        begin
            @(posedge hclk);
            ctl[pb[i]] <= 1'b1;
            run <= 1'b0;
            repeat (SILENT + 8) @(posedge hclk);
            `CHK("paused", 0, active);
            `CHK("paused req", 0, req);
            ctl <= '0;
            run <= 1'b1;
            repeat (2) @(posedge hclk);
            `CHK("resumed", 1, active);
        end
        ctl.cpu_clock_status <= 1'b1;
        repeat (SILENT + 8) @(posedge hclk);
        `CHK("sub idle run", 1, active);
        ctl.main_osc_halt <= 1'b1;
        run <= 1'b0;
        repeat (SILENT + 8) @(posedge hclk);
        `CHK("halt req", 0, req);
        ctl.main_osc_halt <= 1'b0;
        run <= 1'b1;
        repeat (4) @(posedge hclk);
        `CHK("still sub", 0, active);
        ctl.cpu_clock_status <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK("main back", 1, active);
        $display("test pauses done");
        run <= 1'b0;
        repeat (SILENT - 8) @(posedge hclk);
        `CHK("early req", 0, req);
        repeat (16) @(posedge hclk);
        `CHK("stop req", 1, req);
        `CHK("stop flag", 1, flag);
        rdc("stat req", CSM_STAT_OFS, 2);
        rdc("rsrc flag", CSM_RSRC_OFS, 1);
        // software clears the reset-source flag by writing 1
        xfer(1'b1, CSM_RSRC_OFS, 3'b010, 32'h00000001);
        rdc("rsrc cleared", CSM_RSRC_OFS, 0);
        `CHK("req held", 1, req);
        $display("test stop done");
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("mode ext reset", CSM_MODE_OFS, 0);
        `CHK("off after reset", 0, active);
        run <= 1'b1;
        repeat (8) @(posedge hclk);
        prot(3'b010, 32'h00000001);
        // the enable flop only updates at the edge that ends the write
        @(posedge hclk);
        `CHK("re-enabled", 1, active);
        $display("test external reset done");
        conclude();
    end
endmodule : test_csm_monitor
